// ---- udcc_top.sv ----
// usb device core control: enable, freeze, resets, interrupts, dpll
`timescale 1ns/100ps
`default_nettype none
// How it works
// - chip reset leaves controller disabled and in its reset state
// - end of bus reset, when selected, resets logic but keeps enable
// - reset state freezes the controller clock; freeze bit reads one
// - reset state: disabled, bus suspended, device state machine initial
// - memory access bit and 11-bit pointer writable in reset; memory kept
// - speed configuration stays writable in reset state
// - setting enable leaves reset state for device operating state
// - clearing enable at any time resets state machine, endpoint flags, banks and dpll, and freezes clock; general flags and all masks kept
// - two interrupt outputs: general bus events and endpoint events
// - events other than wake-up detected only while clock not frozen
// - wake-up flagged on every data line change even when frozen
// - each endpoint has eight sources, each with flag and enable
// - any enabled endpoint source requests the endpoint interrupt
// - readable per-endpoint summary; flags stay readable for polling
// - logic runs from 48 MHz reference fed from crystal input
// - dpll recovers 12 MHz bit clock from data, times transmit
// - two banks alternate per endpoint without software help
// - endpoint memory 176 bytes, five endpoints of at most 64 bytes
// - enable is bit 7 of general control; clear disables transceiver
// - freeze is bit 5 of general control; gates clocks, keeps resume
module udcc_top #(
  parameter int NUM_EP = udcc_pkg::NUM_EP,
  parameter int MEM_BYTES = udcc_pkg::MEM_BYTES
) (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic DP_IN,
  input wire logic DM_IN,
  input wire logic BUS_RESET_END,
  input wire logic EOR_RESET_SEL,
  input wire logic SOF_EVENT,
  input wire logic [NUM_EP-1:0] EP_BANK_DONE,
  input wire logic [NUM_EP*8-1:0] EP_EVENT,
  output logic GEN_IRQ,
  output logic EP_IRQ,
  output logic XCVR_ON,
  output logic CORE_CLK_EN,
  output logic SUSPENDED,
  output logic BIT_STROBE,
  output logic [NUM_EP-1:0] EP_BANK
);
  logic en_q, frz_q, dma_q;
  logic [10:0] ptr_q;
  logic [7:0] spd_q;
  logic [7:0] gflag_q, gmask_q;
  logic [2:0] epsel_q;
  logic [7:0] epflag_q [NUM_EP];
  logic [7:0] epmask_q [NUM_EP];
  logic [NUM_EP-1:0] epsum;
  logic [NUM_EP-1:0] bank_q;
  logic [7:0] mem_q [MEM_BYTES];
  logic [7:0] rdata_q;
  udcc_pkg::udcc_state_t st_q;
  logic dp_s1, dp_s2, dm_s1, dm_s2, dp_p, dm_p;
  logic eor_s1, eor_s2, eor_p, sof_s1, sof_s2;
  logic [NUM_EP*8-1:0] ev_s1, ev_s2;
  logic [NUM_EP-1:0] bk_s1, bk_s2;
  logic run, blk_rst, wr_gen;
  logic [1:0] dpll_q;
  logic bit_q;

  // pin synchronisers
  always_ff @(posedge CLOCK) begin
    dp_s1 <= DP_IN;
    dp_s2 <= dp_s1;
    dm_s1 <= DM_IN;
    dm_s2 <= dm_s1;
    eor_s1 <= BUS_RESET_END;
    eor_s2 <= eor_s1;
    sof_s1 <= SOF_EVENT;
    sof_s2 <= sof_s1;
    ev_s1 <= EP_EVENT;
    ev_s2 <= ev_s1;
    bk_s1 <= EP_BANK_DONE;
    bk_s2 <= bk_s1;
    dp_p <= dp_s2;
    dm_p <= dm_s2;
    eor_p <= eor_s2;
  end

  assign wr_gen = WR && ADDR == udcc_pkg::ADDR_GENCTRL;
  // controller runs only when enabled and not frozen
  assign run = en_q && !frz_q;
  // bus end-of-reset pulse resets logic when selected
  assign blk_rst = !en_q || (EOR_RESET_SEL && eor_s2 && !eor_p);

  // general control: enable and freeze
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      en_q <= 1'b0;
      frz_q <= 1'b1;
    end else if (wr_gen) begin
      en_q <= WDATA[udcc_pkg::BIT_ENABLE];
      frz_q <= WDATA[udcc_pkg::BIT_FREEZE] || !WDATA[udcc_pkg::BIT_ENABLE];
    end
  end

  // device state machine
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      st_q <= udcc_pkg::UDCC_RESET;
    end else if (!en_q) begin
      st_q <= udcc_pkg::UDCC_RESET;
    end else begin
      case (st_q)
        udcc_pkg::UDCC_RESET: st_q <= udcc_pkg::UDCC_DEVICE;
        udcc_pkg::UDCC_DEVICE: begin
          if (blk_rst) begin
            st_q <= udcc_pkg::UDCC_BUSRST;
          end
        end
        udcc_pkg::UDCC_BUSRST: st_q <= udcc_pkg::UDCC_DEVICE;
        default: st_q <= udcc_pkg::UDCC_RESET;
      endcase
    end
  end

  // memory access and speed config, writable even in reset state
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      dma_q <= 1'b0;
      ptr_q <= 11'h000;
      spd_q <= 8'h00;
    end else if (WR) begin
      case (ADDR)
        udcc_pkg::ADDR_DMACTRL: dma_q <= WDATA[udcc_pkg::BIT_DMA];
        udcc_pkg::ADDR_PTR_LO: ptr_q[7:0] <= WDATA;
        udcc_pkg::ADDR_PTR_HI: ptr_q[10:8] <= WDATA[2:0];
        udcc_pkg::ADDR_SPEED: spd_q <= WDATA;
        udcc_pkg::ADDR_MEM_DATA: begin
          if (dma_q) begin
            ptr_q <= ptr_q + 11'h001;
          end
        end
        default: ;
      endcase
    end else if (RD && ADDR == udcc_pkg::ADDR_MEM_DATA && dma_q) begin
      ptr_q <= ptr_q + 11'h001;
    end
  end

  // endpoint memory never cleared by any reset
  always_ff @(posedge CLOCK) begin
    if (WR && ADDR == udcc_pkg::ADDR_MEM_DATA && dma_q && ptr_q < 11'(MEM_BYTES)) begin
      mem_q[ptr_q[7:0]] <= WDATA;
    end
  end

  // general event flags; write one to clear, set wins
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      gflag_q <= 8'h00;
      gmask_q <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if ((i == udcc_pkg::GEN_BIT_WAKE && ((dp_s2 ^ dp_p) || (dm_s2 ^ dm_p))) ||
            (i == udcc_pkg::GEN_BIT_EOR && run && eor_s2 && !eor_p) ||
            (i == udcc_pkg::GEN_BIT_SOF && run && sof_s2)) begin
          gflag_q[i] <= 1'b1;
        end else if (WR && ADDR == udcc_pkg::ADDR_GENFLAG && WDATA[i]) begin
          gflag_q[i] <= 1'b0;
        end
      end
      if (WR && ADDR == udcc_pkg::ADDR_GENMASK) begin
        gmask_q <= WDATA;
      end
    end
  end

  // endpoint flags and enables
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      epsel_q <= 3'h0;
      for (int e = 0; e < NUM_EP; e++) begin
        epflag_q[e] <= 8'h00;
        epmask_q[e] <= 8'h00;
      end
    end else begin
      if (WR && ADDR == udcc_pkg::ADDR_EP_SEL) begin
        epsel_q <= WDATA[2:0];
      end
      for (int e = 0; e < NUM_EP; e++) begin
        for (int b = 0; b < 8; b++) begin
          if (blk_rst) begin
            epflag_q[e][b] <= 1'b0;
          end else if (run && ev_s2[e*8+b]) begin
            epflag_q[e][b] <= 1'b1;
          end else if (WR && ADDR == udcc_pkg::ADDR_EP_FLAG && 3'(e) == epsel_q && WDATA[b]) begin
            epflag_q[e][b] <= 1'b0;
          end
        end
        if (WR && ADDR == udcc_pkg::ADDR_EP_MASK && 3'(e) == epsel_q) begin
          epmask_q[e] <= WDATA;
        end
      end
    end
  end

  always_comb begin
    for (int e = 0; e < NUM_EP; e++) begin
      epsum[e] = |(epflag_q[e] & epmask_q[e]);
    end
  end

  // ping-pong bank toggles on each completed bank
  always_ff @(posedge CLOCK) begin
    if (RESET || blk_rst) begin
      bank_q <= '0;
    end else if (run) begin
      bank_q <= bank_q ^ bk_s2;
    end
  end

  // dpll: resync a divide-by-four phase on every dp transition
  always_ff @(posedge CLOCK) begin
    if (RESET || !run) begin
      dpll_q <= 2'h0;
      bit_q <= 1'b0;
    end else begin
      if (dp_s2 ^ dp_p) begin
        dpll_q <= 2'h0;
      end else begin
        dpll_q <= dpll_q + 2'h1;
      end
      bit_q <= dpll_q == 2'(udcc_pkg::DPLL_DIV / 2 - 1);
    end
  end

  // read port, data one cycle after strobe
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      rdata_q <= 8'h00;
    end else if (RD) begin
      case (ADDR)
        udcc_pkg::ADDR_GENCTRL: rdata_q <= {en_q, 1'b0, frz_q, 5'h00};
        udcc_pkg::ADDR_DMACTRL: rdata_q <= {dma_q, 7'h00};
        udcc_pkg::ADDR_PTR_LO: rdata_q <= ptr_q[7:0];
        udcc_pkg::ADDR_PTR_HI: rdata_q <= {5'h00, ptr_q[10:8]};
        udcc_pkg::ADDR_SPEED: rdata_q <= spd_q;
        udcc_pkg::ADDR_GENFLAG: rdata_q <= gflag_q;
        udcc_pkg::ADDR_GENMASK: rdata_q <= gmask_q;
        udcc_pkg::ADDR_EP_SEL: rdata_q <= {5'h00, epsel_q};
        udcc_pkg::ADDR_EP_FLAG: rdata_q <= epsel_q < 3'(NUM_EP) ? epflag_q[epsel_q] : 8'h00;
        udcc_pkg::ADDR_EP_MASK: rdata_q <= epsel_q < 3'(NUM_EP) ? epmask_q[epsel_q] : 8'h00;
        udcc_pkg::ADDR_EP_SUM: rdata_q <= 8'(epsum);
        udcc_pkg::ADDR_STATUS: rdata_q <= {4'h0, dp_s2, dm_s2, st_q};
        udcc_pkg::ADDR_MEM_DATA: rdata_q <= (dma_q && ptr_q < 11'(MEM_BYTES)) ? mem_q[ptr_q[7:0]] : 8'h00;
        default: rdata_q <= 8'h00;
      endcase
    end
  end
  assign RDATA = rdata_q;

  // registered outputs
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      GEN_IRQ <= 1'b0;
      EP_IRQ <= 1'b0;
      XCVR_ON <= 1'b0;
      CORE_CLK_EN <= 1'b0;
      SUSPENDED <= 1'b1;
      BIT_STROBE <= 1'b0;
      EP_BANK <= '0;
    end else begin
      GEN_IRQ <= |(gflag_q & gmask_q);
      EP_IRQ <= |epsum;
      XCVR_ON <= en_q;
      CORE_CLK_EN <= run;
      SUSPENDED <= !en_q;
      BIT_STROBE <= bit_q;
      EP_BANK <= bank_q;
    end
  end

  property p_chip_reset;
    @(posedge CLOCK) RESET |=> !en_q && frz_q && st_q == udcc_pkg::UDCC_RESET;
  endproperty
  a_chip_reset: assert property (p_chip_reset) else $error("reset not applied");
  property p_eor_keeps_en;
    @(posedge CLOCK) disable iff (RESET) (en_q && blk_rst && !wr_gen) |=> en_q;
  endproperty
  a_eor_keeps_en: assert property (p_eor_keeps_en) else $error("enable lost");
  property p_freeze_reads;
    @(posedge CLOCK) disable iff (RESET) (!en_q) |-> frz_q;
  endproperty
  a_freeze_reads: assert property (p_freeze_reads) else $error("freeze clear when disabled");
  property p_enter_device;
    @(posedge CLOCK) disable iff (RESET) (wr_gen && WDATA[udcc_pkg::BIT_ENABLE]) |=> ##1 st_q != udcc_pkg::UDCC_RESET;
  endproperty
  a_enter_device: assert property (p_enter_device) else $error("no device state");
  property p_frozen_ep;
    @(posedge CLOCK) disable iff (RESET) (!run && !blk_rst && !WR) |=> epflag_q[0] == $past(epflag_q[0]);
  endproperty
  a_frozen_ep: assert property (p_frozen_ep) else $error("flag set while frozen");
  property p_ep_irq;
    @(posedge CLOCK) disable iff (RESET) (|epsum) |=> EP_IRQ;
  endproperty
  a_ep_irq: assert property (p_ep_irq) else $error("endpoint irq missing");
  property p_wake;
    @(posedge CLOCK) disable iff (RESET) (dp_s2 != dp_p) |=> gflag_q[udcc_pkg::GEN_BIT_WAKE];
  endproperty
  a_wake: assert property (p_wake) else $error("wake missed");
  property p_xcvr;
    @(posedge CLOCK) disable iff (RESET) (!en_q) |=> !XCVR_ON && !CORE_CLK_EN;
  endproperty
  a_xcvr: assert property (p_xcvr) else $error("transceiver on while disabled");

  // selected end of bus reset: one synchronised rising edge
  sequence s_eor_edge;
    eor_s2 && !eor_p;
  endsequence

  // banks and endpoint 0 flags back at their initial values
  sequence s_logic_cleared;
    bank_q == '0 && epflag_q[0] == 8'h00;
  endsequence

  // bus reset clears flags and banks of the running device
  property p_eor_clears;
    @(posedge CLOCK) disable iff (RESET) (en_q && EOR_RESET_SEL) ##0 s_eor_edge |=> s_logic_cleared;
  endproperty
  a_eor_clears: assert property (p_eor_clears) else $error("bus reset left state");

  // frozen clock: only wake may still raise a general flag
  property p_frozen_gen;
    @(posedge CLOCK) disable iff (RESET) (!run && !(WR && ADDR == udcc_pkg::ADDR_GENFLAG)) |=> $stable(gflag_q[2:1]);
  endproperty
  a_frozen_gen: assert property (p_frozen_gen) else $error("general flag set while frozen");

  // enabled general flag requests the general vector
  property p_gen_irq;
    @(posedge CLOCK) disable iff (RESET) (|(gflag_q & gmask_q)) |=> GEN_IRQ;
  endproperty
  a_gen_irq: assert property (p_gen_irq) else $error("general irq missing");

  // completed bank flips the endpoint to its other bank
  property p_bank_toggle;
    @(posedge CLOCK) disable iff (RESET) (run && !blk_rst && bk_s2[0]) |=> bank_q[0] != $past(bank_q[0]);
  endproperty
  a_bank_toggle: assert property (p_bank_toggle) else $error("bank did not switch");

  // disabled controller reports the bus as suspended
  property p_suspended;
    @(posedge CLOCK) disable iff (RESET) (!en_q) |=> SUSPENDED;
  endproperty
  a_suspended: assert property (p_suspended) else $error("not suspended while disabled");

  // bit strobe is a single cycle pulse
  property p_strobe_single;
    @(posedge CLOCK) disable iff (RESET) bit_q |=> !bit_q;
  endproperty
  a_strobe_single: assert property (p_strobe_single) else $error("bit strobe too long");

  // memory data read steps the pointer, reset state or not
  property p_ptr_step;
    @(posedge CLOCK) disable iff (RESET) (RD && !WR && ADDR == udcc_pkg::ADDR_MEM_DATA && dma_q) |=> ptr_q == $past(ptr_q) + 11'h001;
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer did not advance");

  // frozen clock keeps the core clock gated off
  property p_freeze_gates;
    @(posedge CLOCK) disable iff (RESET) frz_q |=> !CORE_CLK_EN;
  endproperty
  a_freeze_gates: assert property (p_freeze_gates) else $error("clock runs while frozen");

  // enabled controller keeps its transceiver on
  property p_xcvr_on;
    @(posedge CLOCK) disable iff (RESET) en_q |=> XCVR_ON;
  endproperty
  a_xcvr_on: assert property (p_xcvr_on) else $error("transceiver off while enabled");
endmodule
`default_nettype wire

// ---- udcc_pkg.sv ----
// constants and types for the usb device core control block
package udcc_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_GENCTRL = 4'h0;
  localparam logic [3:0] ADDR_DMACTRL = 4'h1;
  localparam logic [3:0] ADDR_PTR_LO = 4'h2;
  localparam logic [3:0] ADDR_PTR_HI = 4'h3;
  localparam logic [3:0] ADDR_SPEED = 4'h4;
  localparam logic [3:0] ADDR_GENFLAG = 4'h5;
  localparam logic [3:0] ADDR_GENMASK = 4'h6;
  localparam logic [3:0] ADDR_EP_SEL = 4'h7;
  localparam logic [3:0] ADDR_EP_FLAG = 4'h8;
  localparam logic [3:0] ADDR_EP_MASK = 4'h9;
  localparam logic [3:0] ADDR_EP_SUM = 4'hA;
  localparam logic [3:0] ADDR_STATUS = 4'hB;
  localparam logic [3:0] ADDR_MEM_DATA = 4'hC;
  localparam int BIT_ENABLE = 7;
  localparam int BIT_FREEZE = 5;
  localparam int BIT_DMA = 7;
  localparam int PTR_W = 11;
  localparam int MEM_BYTES = 176;
  localparam int EP_MAX_BYTES = 64;
  localparam int NUM_EP = 5;
  localparam int EP_SRC = 8;
  localparam int GEN_BIT_WAKE = 0;
  localparam int GEN_BIT_EOR = 1;
  localparam int GEN_BIT_SOF = 2;
  localparam int REF_CLK_HZ = 48000000;
  localparam int BIT_CLK_HZ = 12000000;
  localparam int DPLL_DIV = REF_CLK_HZ / BIT_CLK_HZ;
  localparam logic [7:0] GENCTRL_RST = 8'h20;
  typedef enum logic [1:0] {
    UDCC_RESET = 2'b00,
    UDCC_DEVICE = 2'b01,
    UDCC_BUSRST = 2'b11
  } udcc_state_t;
endpackage

// ---- udcc_host_model.sv ----
// host side model: drives the bus lines and bus-level events
`timescale 1ns/100ps
`default_nettype none
module udcc_host_model (
  input wire logic clock,
  output logic dp,
  output logic dm,
  output logic sof,
  output logic bus_reset_end
);
  // full-speed idle j state
  initial begin
    dp = 1'b1;
    dm = 1'b0;
    sof = 1'b0;
    bus_reset_end = 1'b0;
  end
  // k state for n cycles, then back to j
  task automatic resume_k(input int n);
    @(posedge clock);
    dp <= 1'b0;
    dm <= 1'b1;
    repeat (n) @(posedge clock);
    dp <= 1'b1;
    dm <= 1'b0;
  endtask
  task automatic pulse(input int which);
    @(posedge clock);
    if (which == 0) sof <= 1'b1;
    else bus_reset_end <= 1'b1;
    repeat (3) @(posedge clock);
    sof <= 1'b0;
    bus_reset_end <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- tb_usb_device_core_control.sv ----
// self-checking bench for the usb device core control block
`timescale 1ns/100ps
`default_nettype none
module tb_usb_device_core_control;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic eor_sel = 1'b0;
  logic [4:0] bank_done = 5'h00;
  logic [39:0] ep_event = 40'h0;
  logic [7:0] rdata;
  logic [4:0] ep_bank;
  logic dp, dm, sof, bre, gen_irq, ep_irq, xcvr_on, clk_en, suspended, bit_strobe;
  logic [31:0] seed = 32'h00018476;
  logic [7:0] v;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int e, b, p;
  always #20 clock = ~clock;
  udcc_host_model udcc_host_model_i (.clock(clock), .dp(dp), .dm(dm), .sof(sof), .bus_reset_end(bre));
  udcc_top udcc_top_i (.CLOCK(clock), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .DP_IN(dp), .DM_IN(dm), .BUS_RESET_END(bre), .EOR_RESET_SEL(eor_sel),
    .SOF_EVENT(sof), .EP_BANK_DONE(bank_done), .EP_EVENT(ep_event), .GEN_IRQ(gen_irq),
    .EP_IRQ(ep_irq), .XCVR_ON(xcvr_on), .CORE_CLK_EN(clk_en), .SUSPENDED(suspended),
    .BIT_STROBE(bit_strobe), .EP_BANK(ep_bank));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors = errors + 1;
      results();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic done(input string s);
    $display("test %0s done", s);
  endtask
  initial begin
    cyc(16);
    reset <= 1'b0;
    rreg(udcc_pkg::ADDR_GENCTRL, v);
    chk(v, udcc_pkg::GENCTRL_RST);
    chk(xcvr_on, 1'b0);
    chk(suspended, 1'b1);
    chk(clk_en, 1'b0);
    done("reset state");
    seed = lfsr(seed);
    p = seed[6:0];
    wreg(udcc_pkg::ADDR_DMACTRL, 8'h80);
    wreg(udcc_pkg::ADDR_PTR_LO, p[7:0]);
    wreg(udcc_pkg::ADDR_PTR_HI, 8'h00);
    wreg(udcc_pkg::ADDR_MEM_DATA, seed[15:8]);
    wreg(udcc_pkg::ADDR_SPEED, {6'h00, seed[17:16]});
    rreg(udcc_pkg::ADDR_PTR_LO, v);
    chk(v, p[7:0] + 8'h01);
    wreg(udcc_pkg::ADDR_PTR_LO, p[7:0]);
    rreg(udcc_pkg::ADDR_MEM_DATA, v);
    chk(v, seed[15:8]);
    rreg(udcc_pkg::ADDR_SPEED, v);
    chk(v, {6'h00, seed[17:16]});
    done("writable in reset");
    wreg(udcc_pkg::ADDR_GENCTRL, 8'h80);
    cyc(2);
    chk({xcvr_on, clk_en, suspended}, 8'h06);
    seed = lfsr(seed);
    e = seed % 5;
    @(posedge clock) bank_done[e] <= 1'b1;
    @(posedge clock) bank_done[e] <= 1'b0;
    cyc(4);
    chk(ep_bank, 8'h01 << e);
    p = 0;
    repeat (40) begin
      @(posedge clock);
      #1;
      if (bit_strobe === 1'b1) p++;
    end
    chk(p[7:0], 8'(40 / udcc_pkg::DPLL_DIV));
    done("enable and banks");
    wreg(udcc_pkg::ADDR_GENMASK, 8'h05);
    wreg(udcc_pkg::ADDR_GENCTRL, 8'hA0);
    cyc(2);
    chk(clk_en, 1'b0);
    wreg(udcc_pkg::ADDR_GENFLAG, 8'hFF);
    udcc_host_model_i.pulse(0);
    cyc(6);
    rreg(udcc_pkg::ADDR_GENFLAG, v);
    chk(v, 8'h00);
    udcc_host_model_i.resume_k(4);
    cyc(6);
    rreg(udcc_pkg::ADDR_GENFLAG, v);
    chk(v, 8'h01);
    chk(gen_irq, 1'b1);
    wreg(udcc_pkg::ADDR_GENFLAG, 8'h01);
    wreg(udcc_pkg::ADDR_GENCTRL, 8'h80);
    udcc_host_model_i.pulse(0);
    cyc(6);
    rreg(udcc_pkg::ADDR_GENFLAG, v);
    chk(v, 8'h04);
    wreg(udcc_pkg::ADDR_GENFLAG, 8'h04);
    cyc(3);
    chk(gen_irq, 1'b0);
    done("general events");
    seed = lfsr(seed);
    e = seed % 5;
    b = seed[10:8];
    wreg(udcc_pkg::ADDR_EP_SEL, e[7:0]);
    wreg(udcc_pkg::ADDR_EP_MASK, 8'h00);
    @(posedge clock) ep_event[e*8+b] <= 1'b1;
    repeat (3) @(posedge clock);
    ep_event[e*8+b] <= 1'b0;
    cyc(6);
    rreg(udcc_pkg::ADDR_EP_FLAG, v);
    chk(v, 8'h01 << b);
    chk(ep_irq, 1'b0);
    wreg(udcc_pkg::ADDR_EP_MASK, 8'h01 << b);
    cyc(4);
    chk(ep_irq, 1'b1);
    rreg(udcc_pkg::ADDR_EP_SUM, v);
    chk(v, 8'h01 << e);
    done("endpoint events");
    eor_sel <= 1'b1;
    udcc_host_model_i.pulse(1);
    cyc(6);
    chk(xcvr_on, 1'b1);
    chk(ep_bank, 8'h00);
    rreg(udcc_pkg::ADDR_EP_FLAG, v);
    chk(v, 8'h00);
    wreg(udcc_pkg::ADDR_GENCTRL, 8'h00);
    cyc(2);
    chk({xcvr_on, suspended}, 8'h01);
    rreg(udcc_pkg::ADDR_GENCTRL, v);
    chk(v, udcc_pkg::GENCTRL_RST);
    done("bus reset and disable");
    results();
  end
endmodule
`default_nettype wire
